// [bench/block_move_monitor.sv]
// block_move_monitor: port assertions for the block move sequencer
// assumes clk_en high; reset is raw nrst, the synced copy lags it
`timescale 1ns/1ps
module block_move_monitor import block_move_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic start,
  input wire move_cmd_t cmd,
  input wire logic busy,
  input wire logic done,
  input wire move_result_t result,
  input wire mem_req_t mem_req,
  input wire logic mem_gnt,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic slow_sync,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] flags_out
);
  move_cmd_t cap_ff;
  logic [15:0] n;
  logic z;
  logic [4:0] quiet_ff;
  // consecutive samples with the slow clock wait low, saturating
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst) quiet_ff <= 5'h00;
    else if (slow_sync) quiet_ff <= 5'h00;
    else if (quiet_ff != 5'h1F) quiet_ff <= quiet_ff + 5'h01;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst) cap_ff <= '0;
    else if (start && !busy) cap_ff <= cmd;
  assign n = cap_ff.word_form ? cap_ff.count : {8'h00, cap_ff.count[7:0]};
  assign z = cmd.word_form ? cmd.count == 16'h0000 : cmd.count[7:0] == 8'h00;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_rd_wr;
    mem_req.req && mem_gnt && !mem_req.we |=> !mem_req.req || mem_req.we;
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("read not followed by write");
  property p_hold;
    mem_req.req && !mem_gnt |=> mem_req.req && $stable(mem_req.addr) && $stable(mem_req.we)
      && $stable(mem_req.wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped or changed");
  property p_ptrs;
    done |-> result.src == cap_ff.src + n && result.dst == cap_ff.dst + n;
  endproperty
  a_ptrs: assert property (p_ptrs) else $error("final pointers wrong");
  property p_cnt;
    done |-> result.count == (cap_ff.word_form ? 16'h0000 : {cap_ff.count[15:8], 8'h00});
  endproperty
  a_cnt: assert property (p_cnt) else $error("final count wrong");
  property p_zero;
    start && !busy && z ##10 quiet_ff >= 5'h0C |-> done;
  endproperty
  a_zero: assert property (p_zero) else $error("zero count timing wrong");
  property p_stall;
    slow_sync [*4] ##0 !mem_req.req |=> !mem_req.req;
  endproperty
  a_stall: assert property (p_stall) else $error("request issued while stalled");
  property p_flags;
    flags_out == flags_in;
  endproperty
  a_flags: assert property (p_flags) else $error("flags changed");
endmodule // block_move_monitor
bind block_move_sequencer block_move_monitor mon (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
  .start(start), .cmd(cmd), .busy(busy), .done(done), .result(result), .mem_req(mem_req),
  .mem_gnt(mem_gnt), .mem_rdata(mem_rdata), .slow_sync(slow_sync), .flags_in(flags_in),
  .flags_out(flags_out));

// [bench/move_memory.sv]
// move_memory: byte memory answering the sequencer's port after wait_cyc cycles
// assumes byte i preloaded as i xor 5A; idle read data toggles so stale bytes never match
`timescale 1ns/1ps
module move_memory import block_move_pkg::*; (
  input wire logic sys_clk,
  input wire mem_req_t mem_req,
  input wire logic [3:0] wait_cyc,
  output logic mem_gnt,
  output logic [DATA_W-1:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] junk = 8'h00;
  int cnt = 0;
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'h5A;
  assign mem_gnt = mem_req.req && cnt >= int'(wait_cyc);
  assign mem_rdata = mem_gnt && !mem_req.we ? mem[mem_req.addr] : junk;
  always @(posedge sys_clk) begin
    cnt <= mem_req.req && !mem_gnt ? cnt + 1 : 0;
    if (mem_gnt && mem_req.we) mem[mem_req.addr] <= mem_req.wdata;
    junk <= ~junk;
  end
endmodule // move_memory

// [bench/testbench.sv]
// testbench: runs block moves against the memory model and checks pointers, data, timing
// assumes clk_en held high; memory preload is address xor 5A
`timescale 1ns/1ps
module testbench import block_move_pkg::*;;
  logic sys_clk = 0, nrst = 0, start = 0, slow_sync = 0, busy, done, mem_gnt;
  logic [7:0] flags_in = 8'hA5, flags_out, mem_rdata;
  logic [3:0] wait_cyc = 4'h0;
  move_cmd_t cmd = '0;
  move_result_t result;
  mem_req_t mem_req;
  int failures = 0, cmp_count = 0;
  block_move_sequencer dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1), .start(start), .cmd(cmd),
    .busy(busy), .done(done), .result(result), .mem_req(mem_req), .mem_gnt(mem_gnt),
    .mem_rdata(mem_rdata), .slow_sync(slow_sync), .flags_in(flags_in), .flags_out(flags_out));
  move_memory mem_i (.sys_clk(sys_clk), .mem_req(mem_req), .wait_cyc(wait_cyc), .mem_gnt(mem_gnt),
    .mem_rdata(mem_rdata));
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one move; cyc counts edges from start to the done pulse
  task automatic move(input logic wf, input logic [15:0] src, input logic [15:0] dst,
    input logic [15:0] cnt, output int cyc);
    logic [15:0] n;
    n = wf ? cnt : {8'h00, cnt[7:0]};
    @(posedge sys_clk); #1;
    cmd = '{wf, src, dst, cnt};
    start = 1;
    @(posedge sys_clk); #1;
    start = 0;
    cyc = 1;
    cmp(busy, 1'b1);
    while (done !== 1'b1 && cyc < 6000) begin
      @(posedge sys_clk); #1;
      cyc++;
    end
    if (done !== 1'b1) begin
      failures++;
      $display("FAIL t=%0t move did not finish", $time);
    end
    cmp(busy, 1'b0);
    cmp(result, {src + n, dst + n, wf ? 16'h0000 : {cnt[15:8], 8'h00}});
    for (int i = 0; i < int'(n); i++) cmp(mem_i.mem[dst + 16'(i)], 8'(src + 16'(i)) ^ 8'h5A);
  endtask
  task automatic t_skip;
    int c;
    move(0, 16'h1000, 16'h2000, 16'h1200, c);
    cmp(c, 10);
    move(1, 16'h1000, 16'h2000, 16'h0000, c);
    cmp(c, 10);
    $display("t_skip over");
  endtask
  task automatic t_byte;
    int c;
    move(0, 16'h1100, 16'h2100, 16'hAB03, c);
    cmp(c, 8 + 4 * 3 + 2);
    flags_in = 8'h3C;
    #1 cmp(flags_out, 8'h3C);
    $display("t_byte over");
  endtask
  task automatic t_word;
    int c;
    wait_cyc = 4'h2;
    move(1, 16'h3000, 16'h5000, 16'h0120, c);
    wait_cyc = 4'h0;
    $display("t_word over");
  endtask
  task automatic t_slow;
    int c;
    fork
      move(0, 16'h6000, 16'h7000, 16'h0004, c);
      repeat (8) begin
        repeat (5) @(posedge sys_clk);
        #1 slow_sync = ~slow_sync;
      end
      begin
        repeat (5) @(posedge sys_clk);
        #1 cmd.src = 16'h0BAD;
        start = 1;
        @(posedge sys_clk);
        #1 start = 0;
      end
    join
    cmp(c > 8 + 4 * 4 + 2, 1);
    $display("t_slow over");
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 nrst = 1;
    repeat (4) @(posedge sys_clk);
    t_skip;
    t_byte;
    t_word;
    t_slow;
    test_done;
  end
  // a full run is about 2400 cycles
  initial begin
    #200000;
    failures++;
    test_done;
  end
endmodule // testbench

// [rtl/block_move_pkg.sv]
// block_move_pkg: shared constants and carrier types for the block move sequencer
// assumes a byte-wide memory port with request/grant handshake on the processor clock
package block_move_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 16;

  // fixed state overhead and per-byte cost, in processor states
  localparam int FIXED_STATES = 8;
  localparam int STATES_PER_BYTE = 4;
  // one read and one write per byte; the read holds the bus for one state, the write for two
  localparam logic [1:0] BYTE_PHASE_LAST = 2'h3;
  localparam logic [3:0] OVERHEAD_LAST = 4'h7;

  localparam logic [ADDR_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b011,
    ST_PAD = 3'b100,
    ST_DONE = 3'b101
  } move_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic req;
  } mem_req_t;

  typedef struct packed {
    logic word_form;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [CNT_W-1:0] count;
  } move_cmd_t;

  typedef struct packed {
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [CNT_W-1:0] count;
  } move_result_t;

  function automatic logic [CNT_W-1:0] active_count(input logic word_form, input logic [CNT_W-1:0] cnt);
    active_count = word_form ? cnt : {8'h00, cnt[7:0]};
  endfunction

endpackage

// [rtl/block_move_sequencer.sv]
// block_move_sequencer: executes the block move instruction as byte reads and writes
// assumes the decoder pulses start with pointers and count, and a memory port with req/gnt
// Function
// - per byte: read at source, write at destination, each pointer bumped by one on its own access's grant
// - byte form: decrement 8-bit low count per byte, stop at zero, zero means skip
// - word form: same with full 16-bit count register
// - on-chip timing: 8 states plus 4 states per byte moved
// - slow peripheral sync stretches states, so state count varies with its phase
`timescale 1ns/1ps
module block_move_sequencer
  import block_move_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic start,
  input wire move_cmd_t cmd,
  output logic busy,
  output logic done,
  output move_result_t result,
  output mem_req_t mem_req,
  input wire logic mem_gnt,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic slow_sync,
  input wire logic [7:0] flags_in,
  output logic [7:0] flags_out
);

  typedef struct packed {
    move_state_t state;
    logic word_form;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] reads_left;
    logic [3:0] lead;
    logic [1:0] phase;
    logic done;
    mem_req_t req;
    move_result_t res;
  } seq_state_t;

  seq_state_t st_ff;
  seq_state_t nxt_st;
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic sync_meta_ff;
  logic sync_ff;
  logic rd_fire;
  logic wr_fire;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic stretch;

  localparam seq_state_t SEQ_RESET = '{
    state: ST_IDLE,
    word_form: 1'b0,
    src: PTR_RESET,
    dst: PTR_RESET,
    count: CNT_RESET,
    reads_left: CNT_RESET,
    lead: 4'h0,
    phase: 2'h0,
    done: 1'b0,
    req: '0,
    res: '{src: PTR_RESET, dst: PTR_RESET, count: CNT_RESET}
  };

  // read request at the given pointer; issued from three states
  function automatic mem_req_t read_req(input logic [ADDR_W-1:0] ptr);
    read_req = '{addr: ptr, wdata: '0, we: 1'b0, req: 1'b1};
  endfunction

  // pointers wrap at the top of the 16-bit space, as the registers do
  function automatic logic [ADDR_W-1:0] step_up(input logic [ADDR_W-1:0] v);
    step_up = v + 16'h0001;
  endfunction

  function automatic logic [CNT_W-1:0] step_down(input logic [CNT_W-1:0] v);
    step_down = v - 16'h0001;
  endfunction

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // peripheral clock wait comes from another domain
  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      sync_meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (clk_en) begin
      sync_meta_ff <= slow_sync;
      sync_ff <= sync_meta_ff;
    end
  end

  assign stretch = sync_ff;
  assign rd_fire = st_ff.state == ST_READ && st_ff.req.req && mem_gnt && !st_ff.req.we;
  assign wr_fire = st_ff.state == ST_WRITE && st_ff.req.req && mem_gnt && st_ff.req.we;

  // read data lands in the FIFO; write side drains it, so a stalled write backs up reads
  move_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_sync_ff),
    .clk_en(clk_en),
    .in_valid(rd_fire),
    .in_ready(fifo_in_ready),
    .in_data(mem_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(wr_fire),
    .out_data(fifo_out_data)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.state)
      ST_IDLE: begin
        nxt_st.req = '0;
        if (start) begin
          nxt_st.word_form = cmd.word_form;
          nxt_st.src = cmd.src;
          nxt_st.dst = cmd.dst;
          nxt_st.count = cmd.count;
          nxt_st.reads_left = active_count(cmd.word_form, cmd.count);
          nxt_st.lead = '0;
          nxt_st.state = ST_LEAD;
        end
      end
      ST_LEAD: begin
        // fixed overhead counted once per instruction
        if (!stretch) begin
          nxt_st.lead = st_ff.lead + 4'h1;
        end
        if (st_ff.lead == OVERHEAD_LAST && !stretch) begin
          if (st_ff.reads_left == CNT_ZERO) begin
            nxt_st.state = ST_DONE;
          end else begin
            nxt_st.phase = '0;
            nxt_st.state = ST_READ;
            nxt_st.req = read_req(st_ff.src);
          end
        end
      end
      ST_READ: begin
        if (!st_ff.req.req && fifo_in_ready && !stretch) begin
          nxt_st.req = read_req(st_ff.src);
        end
        if (rd_fire) begin
          nxt_st.req.req = 1'b0;
          nxt_st.src = step_up(st_ff.src);
          nxt_st.reads_left = step_down(st_ff.reads_left);
          nxt_st.state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (!st_ff.req.req && fifo_out_valid && !stretch) begin
          nxt_st.req = '{addr: st_ff.dst, wdata: fifo_out_data, we: 1'b1, req: 1'b1};
        end
        if (wr_fire) begin
          nxt_st.req = '0;
          nxt_st.dst = step_up(st_ff.dst);
          if (st_ff.word_form) begin
            nxt_st.count = step_down(st_ff.count);
          end else begin
            nxt_st.count[7:0] = st_ff.count[7:0] - 8'h01;
          end
          // read, write issue and write grant already used three of the byte's four states
          nxt_st.phase = BYTE_PHASE_LAST;
          nxt_st.state = ST_PAD;
        end
      end
      ST_PAD: begin
        // pads each byte to its four states; stretched while the slow clock holds off
        if (!stretch) begin
          nxt_st.phase = st_ff.phase + 2'h1;
        end
        if (st_ff.phase == BYTE_PHASE_LAST && !stretch) begin
          if (st_ff.reads_left == CNT_ZERO) begin
            nxt_st.state = ST_DONE;
          end else begin
            nxt_st.state = ST_READ;
            nxt_st.req = read_req(st_ff.src);
          end
        end
      end
      ST_DONE: begin
        nxt_st.res = '{src: st_ff.src, dst: st_ff.dst, count: st_ff.count};
        nxt_st.done = 1'b1;
        nxt_st.state = ST_IDLE;
      end
      default: begin
        nxt_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff <= SEQ_RESET;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.state != ST_IDLE;
  assign done = st_ff.done;
  assign result = st_ff.res;
  assign mem_req = st_ff.req;
  assign flags_out = flags_in;

endmodule // block_move_sequencer

// [rtl/move_fifo.sv]
// move_fifo: synchronous FIFO holding bytes between the read and write halves of a move
// assumes one clock; reset and clock enable come from the parent
`timescale 1ns/1ps
module move_fifo
  import block_move_pkg::*;
#(
  parameter int WIDTH = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0] wptr;
    logic [PW:0] rptr;
  } fifo_state_t;

  fifo_state_t st_ff;
  fifo_state_t nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st_ff.wptr - st_ff.rptr) != (PW+1)'(DEPTH);
  assign out_valid = st_ff.wptr != st_ff.rptr;
  assign out_data = mem_ff[st_ff.rptr[PW-1:0]];
  assign push = in_valid && in_ready && clk_en;
  assign pop = out_valid && out_ready && clk_en;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wptr = st_ff.wptr + 1'b1;
    end
    if (pop) begin
      nxt_st.rptr = st_ff.rptr + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // storage needs no reset; only the pointers decide what is visible
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_ff[st_ff.wptr[PW-1:0]] <= in_data;
    end
  end

endmodule // move_fifo
